// *** core/spl_link_if.v ***
`timescale 1ns/1ps
`include "spl_defines.vh"
module spl_link_if #(
   parameter DEPTH = `SPL_FIFO_DEPTH,
   parameter AW = 7
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire start_req,
   input wire txf_wvalid,
   output wire txf_wready,
   input wire [8:0] txf_wdata,
   output wire rxf_rvalid,
   input wire rxf_rready,
   output wire [8:0] rxf_rdata,
   input wire tc_req,
   input wire [7:0] tc_data,
   output reg tc_ack,
   output reg tc_rx_valid,
   output reg [7:0] tc_rx_data,
   input wire rx_char_valid,
   input wire [2:0] rx_char_type,
   input wire [7:0] rx_char_data,
   input wire rx_par_err,
   input wire rx_esc_err,
   input wire rx_disconnect,
   output wire rx_enable,
   input wire tx_char_req,
   output reg [2:0] tx_char_type,
   output reg [7:0] tx_char_data,
   output wire tx_enable,
   output reg tx_bit_en
);
   localparam ST_ERR_RESET = 3'h0;
   localparam ST_ERR_WAIT = 3'h1;
   localparam ST_READY = 3'h2;
   localparam ST_STARTED = 3'h3;
   localparam ST_CONNECTING = 3'h4;
   localparam ST_RUN = 3'h5;
   localparam [5:0] FCT_STEP = `SPL_FCT_CREDITS;
   reg [31:0] port_control_reg;
   reg [7:0] init_divisor;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] tmr_ff;
   reg [7:0] init_cnt_ff;
   reg [7:0] rate_cnt_ff;
   reg init_tick_ff;
   reg got_null_ff;
   reg [5:0] tx_credit_ff;
   reg [5:0] nxt_tx_credit;
   reg [5:0] outst_ff;
   reg [5:0] nxt_outst;
   reg credit_err;
   wire link_disable = port_control_reg[`SPL_PC_LINK_DISABLE];
   wire link_start = port_control_reg[`SPL_PC_LINK_START];
   wire auto_start = port_control_reg[`SPL_PC_AUTO_START];
   wire [7:0] run_divisor = port_control_reg[`SPL_PC_RUN_DIV_MSB:`SPL_PC_RUN_DIV_LSB];
   // switch-side fifos
   wire txf_rvalid;
   wire [8:0] txf_rdata;
   reg txf_pop;
   wire [AW:0] txf_count;
   reg rxf_push;
   reg [8:0] rxf_wdata;
   wire rxf_wready;
   wire [AW:0] rxf_count;
   spl_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_txf (
      .pclk(pclk),
      .presetn(presetn),
      .wr_valid(txf_wvalid),
      .wr_ready(txf_wready),
      .wr_data(txf_wdata),
      .rd_valid(txf_rvalid),
      .rd_ready(txf_pop),
      .rd_data(txf_rdata),
      .count(txf_count)
   );
   spl_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_rxf (
      .pclk(pclk),
      .presetn(presetn),
      .wr_valid(rxf_push),
      .wr_ready(rxf_wready),
      .wr_data(rxf_wdata),
      .rd_valid(rxf_rvalid),
      .rd_ready(rxf_rready),
      .rd_data(rxf_rdata),
      .count(rxf_count)
   );
   // apb slave, zero wait states
   wire apb_setup = psel & ~penable;
   wire apb_access = psel & penable;
   wire addr_ok = (paddr == `SPL_OFF_PORT_CTRL) | (paddr == `SPL_OFF_INIT_DIV) |
                  (paddr == `SPL_OFF_CREDIT) | (paddr == `SPL_OFF_STATUS);
   assign pready = 1'b1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_control_reg <= `SPL_RST_PORT_CTRL;
         init_divisor <= `SPL_RST_INIT_DIV;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         if (apb_setup) begin
            pslverr <= ~addr_ok;
            case (paddr)
               `SPL_OFF_PORT_CTRL: prdata <= {16'h0000, port_control_reg[15:8], 5'h00,
                                              port_control_reg[2:0]};
               `SPL_OFF_INIT_DIV: prdata <= {24'h00_0000, init_divisor};
               `SPL_OFF_CREDIT: prdata <= {18'h0_0000, outst_ff, 2'h0, tx_credit_ff};
               `SPL_OFF_STATUS: prdata <= {8'h00, rxf_count, txf_count, 5'h00, state_ff};
               default: prdata <= 32'h0000_0000;
            endcase
         end
         if (apb_access & pwrite) begin
            if (paddr == `SPL_OFF_PORT_CTRL) begin
               port_control_reg <= {16'h0000, pwdata[15:8], 5'h00, pwdata[2:0]};
            end
            if (paddr == `SPL_OFF_INIT_DIV) begin
               init_divisor <= pwdata[7:0];
            end
         end
      end
   end
   // rate dividers
   // the timeout tick always uses init_divisor so the run rate never bends the timeouts
   wire [7:0] cur_div = (state_ff == ST_RUN) ? run_divisor : init_divisor;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_cnt_ff <= 8'h00;
         init_tick_ff <= 1'b0;
         rate_cnt_ff <= 8'h00;
         tx_bit_en <= 1'b0;
      end else begin
         init_tick_ff <= (init_cnt_ff >= init_divisor);
         init_cnt_ff <= (init_cnt_ff >= init_divisor) ? 8'h00 : init_cnt_ff + 8'h01;
         tx_bit_en <= (rate_cnt_ff >= cur_div);
         rate_cnt_ff <= (rate_cnt_ff >= cur_div) ? 8'h00 : rate_cnt_ff + 8'h01;
      end
   end
   // receive side
   // characters arrive already decoded, one per pclk at most, so any line rate the
   // character level can deliver is absorbed here
   assign rx_enable = (state_ff != ST_ERR_RESET);
   wire rx_take = rx_char_valid & rx_enable;
   wire rx_null = rx_take & (rx_char_type == `SPL_CH_NULL);
   wire rx_live = rx_take & got_null_ff & (rx_char_type != `SPL_CH_NULL);
   wire rx_fct = rx_live & (rx_char_type == `SPL_CH_FCT);
   wire rx_nchar = rx_live & ((rx_char_type == `SPL_CH_NCHAR) |
                  (rx_char_type == `SPL_CH_EOP) | (rx_char_type == `SPL_CH_EEP));
   wire rx_time = rx_live & (rx_char_type == `SPL_CH_TIME);
   wire rx_err = rx_enable & (rx_par_err | rx_esc_err | rx_disconnect | credit_err);
   always @* begin
      rxf_push = rx_nchar & (state_ff == ST_RUN);
      rxf_wdata = {1'b0, rx_char_data};
      if (rx_char_type == `SPL_CH_EOP) begin
         rxf_wdata = 9'h100;
      end else if (rx_char_type == `SPL_CH_EEP) begin
         rxf_wdata = 9'h101;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got_null_ff <= 1'b0;
         tc_rx_valid <= 1'b0;
         tc_rx_data <= 8'h00;
      end else begin
         tc_rx_valid <= rx_time & (state_ff == ST_RUN);
         if (rx_time) begin
            tc_rx_data <= rx_char_data;
         end
         if (state_ff == ST_ERR_RESET) begin
            got_null_ff <= 1'b0;
         end else if (rx_null) begin
            got_null_ff <= 1'b1;
         end
      end
   end
   // character selection
   wire [AW:0] rx_free = DEPTH[AW:0] - rxf_count;
   wire fct_ok = (outst_ff <= `SPL_FCT_MAX_OUTST) &&
                 ({{(AW-5){1'b0}}, outst_ff} + `SPL_FCT_CREDITS <= rx_free);
   wire tx_conn_run = (state_ff == ST_CONNECTING) | (state_ff == ST_RUN);
   assign tx_enable = (state_ff == ST_STARTED) | tx_conn_run;
   reg sel_fct;
   reg sel_nchar;
   reg sel_time;
   always @* begin
      sel_time = 1'b0;
      sel_fct = 1'b0;
      sel_nchar = 1'b0;
      if (tx_char_req & tx_enable) begin
         if ((state_ff == ST_RUN) & tc_req & ~tc_ack) begin
            sel_time = 1'b1;
         end else if (tx_conn_run & fct_ok) begin
            sel_fct = 1'b1;
         end else if ((state_ff == ST_RUN) & txf_rvalid & (tx_credit_ff != 6'h00)) begin
            sel_nchar = 1'b1;
         end
      end
      txf_pop = sel_nchar;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_char_type <= `SPL_CH_NULL;
         tx_char_data <= 8'h00;
         tc_ack <= 1'b0;
      end else begin
         tc_ack <= sel_time;
         if (tx_char_req) begin
            tx_char_data <= 8'h00;
            if (sel_time) begin
               tx_char_type <= `SPL_CH_TIME;
               tx_char_data <= tc_data;
            end else if (sel_fct) begin
               tx_char_type <= `SPL_CH_FCT;
            end else if (sel_nchar) begin
               if (!txf_rdata[8]) begin
                  tx_char_type <= `SPL_CH_NCHAR;
                  tx_char_data <= txf_rdata[7:0];
               end else if (txf_rdata[0]) begin
                  tx_char_type <= `SPL_CH_EEP;
               end else begin
                  tx_char_type <= `SPL_CH_EOP;
               end
            end else begin
               tx_char_type <= `SPL_CH_NULL;
            end
         end
      end
   end
   // credit counters
   always @* begin
      nxt_tx_credit = tx_credit_ff;
      nxt_outst = outst_ff;
      credit_err = 1'b0;
      if (rx_fct) begin
         if (tx_credit_ff > `SPL_MAX_CREDIT - `SPL_FCT_CREDITS) begin
            credit_err = 1'b1;
         end else begin
            nxt_tx_credit = tx_credit_ff + FCT_STEP;
         end
      end
      if (sel_nchar) begin
         nxt_tx_credit = nxt_tx_credit - 6'h01;
      end
      if (sel_fct) begin
         nxt_outst = outst_ff + FCT_STEP;
      end
      if (rx_nchar) begin
         if (outst_ff == 6'h00) begin
            credit_err = 1'b1;
         end else begin
            nxt_outst = nxt_outst - 6'h01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_credit_ff <= 6'h00;
         outst_ff <= 6'h00;
      end else if (state_ff == ST_ERR_RESET) begin
         tx_credit_ff <= 6'h00;
         outst_ff <= 6'h00;
      end else begin
         tx_credit_ff <= nxt_tx_credit;
         outst_ff <= nxt_outst;
      end
   end
   // exchange-level state machine
   wire tmo_short = (tmr_ff >= `SPL_TMO_SHORT_TICKS);
   wire tmo_long = (tmr_ff >= `SPL_TMO_LONG_TICKS);
   wire start_ok = ~link_disable & (link_start | start_req | (auto_start & got_null_ff));
   // an fct, data or time-code character before connecting means the far end is out of step
   wire early_char = rx_fct | rx_nchar | rx_time;
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_ERR_RESET: begin
            if (tmo_short) begin
               nxt_state = ST_ERR_WAIT;
            end
         end
         ST_ERR_WAIT: begin
            if (rx_err | early_char) begin
               nxt_state = ST_ERR_RESET;
            end else if (tmo_long) begin
               nxt_state = ST_READY;
            end
         end
         ST_READY: begin
            if (rx_err | early_char) begin
               nxt_state = ST_ERR_RESET;
            end else if (start_ok) begin
               nxt_state = ST_STARTED;
            end
         end
         ST_STARTED: begin
            if (rx_err | early_char | tmo_long | link_disable) begin
               nxt_state = ST_ERR_RESET;
            end else if (got_null_ff) begin
               nxt_state = ST_CONNECTING;
            end
         end
         ST_CONNECTING: begin
            if (rx_err | rx_nchar | rx_time | tmo_long | link_disable) begin
               nxt_state = ST_ERR_RESET;
            end else if (rx_fct) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (rx_err | link_disable) begin
               nxt_state = ST_ERR_RESET;
            end
         end
         default: nxt_state = ST_ERR_RESET;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_ERR_RESET;
         tmr_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         // timer restarts on every state entry and counts init-rate bit periods
         if (nxt_state != state_ff) begin
            tmr_ff <= 8'h00;
         end else if (init_tick_ff && (tmr_ff != 8'hFF)) begin
            tmr_ff <= tmr_ff + 8'h01;
         end
      end
   end
endmodule // spl_link_if

// *** core/spl_defines.vh ***
`ifndef SPL_DEFINES_VH
`define SPL_DEFINES_VH

// register byte offsets
`define SPL_OFF_PORT_CTRL 8'h00
`define SPL_OFF_INIT_DIV 8'h04
`define SPL_OFF_CREDIT 8'h08
`define SPL_OFF_STATUS 8'h0C

// port_control_reg fields
`define SPL_PC_LINK_DISABLE 0
`define SPL_PC_LINK_START 1
`define SPL_PC_AUTO_START 2
`define SPL_PC_RUN_DIV_LSB 8
`define SPL_PC_RUN_DIV_MSB 15

// reset values
`define SPL_RST_PORT_CTRL 32'h0000_0000
`define SPL_RST_INIT_DIV 8'h04

// character types between link interface and character level
`define SPL_CH_NULL 3'h0
`define SPL_CH_FCT 3'h1
`define SPL_CH_NCHAR 3'h2
`define SPL_CH_EOP 3'h3
`define SPL_CH_EEP 3'h4
`define SPL_CH_TIME 3'h5

// flow control figures
`define SPL_FIFO_DEPTH 128
`define SPL_MAX_CREDIT 56
`define SPL_FCT_MAX_OUTST 48
`define SPL_FCT_CREDITS 8

// timeouts, counted in initialization bit periods
`define SPL_INIT_BIT_NS 100
`define SPL_TMO_SHORT_NS 6400
`define SPL_TMO_LONG_NS 12800
`define SPL_TMO_SHORT_TICKS (`SPL_TMO_SHORT_NS / `SPL_INIT_BIT_NS)
`define SPL_TMO_LONG_TICKS (`SPL_TMO_LONG_NS / `SPL_INIT_BIT_NS)

`endif

// *** core/spl_fifo.v ***
`timescale 1ns/1ps
module spl_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 128,
   parameter AW = 7
) (
   input wire pclk,
   input wire presetn,
   input wire wr_valid,
   output wire wr_ready,
   input wire [WIDTH-1:0] wr_data,
   output wire rd_valid,
   input wire rd_ready,
   output wire [WIDTH-1:0] rd_data,
   output wire [AW:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr_ff;
   reg [AW-1:0] rptr_ff;
   reg [AW:0] cnt_ff;
   wire do_wr;
   wire do_rd;

   assign wr_ready = (cnt_ff != DEPTH[AW:0]);
   assign rd_valid = (cnt_ff != {(AW+1){1'b0}});
   assign rd_data = mem[rptr_ff];
   assign count = cnt_ff;
   assign do_wr = wr_valid & wr_ready;
   assign do_rd = rd_valid & rd_ready;

   always @(posedge pclk) begin
      if (do_wr) begin
         mem[wptr_ff] <= wr_data;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_ff <= {AW{1'b0}};
         rptr_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wptr_ff <= wptr_ff + 1'b1;
         end
         if (do_rd) begin
            rptr_ff <= rptr_ff + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (do_rd & ~do_wr) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule // spl_fifo

// *** testbench/spl_link_if_sva.sv ***
`timescale 1ns/1ps
`include "spl_defines.vh"
module spl_link_if_sva (
   input wire pclk,
   input wire presetn,
   input wire rx_par_err,
   input wire rx_esc_err,
   input wire rx_enable,
   input wire tx_enable,
   input wire tx_char_req,
   input wire [2:0] tx_char_type,
   input wire tc_req,
   input wire tc_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // saturating count of cycles spent with the receiver off
   reg [7:0] low_ff;
   wire [7:0] nxt_low = rx_enable ? 8'h00 : (low_ff == 8'hFF ? low_ff : low_ff + 8'h01);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) low_ff <= 8'h00;
      else low_ff <= nxt_low;
   end
   property p_txrx; tx_enable |-> $past(rx_enable); endproperty
   a_txrx: assert property (p_txrx) else $error("transmitter on before receiver");
   property p_wake; $rose(rx_enable) |-> !tx_enable && low_ff >= 8'h3F; endproperty
   a_wake: assert property (p_wake) else $error("error-reset left too early");
   property p_par; rx_par_err && rx_enable |-> ##[1:3] !rx_enable; endproperty
   a_par: assert property (p_par) else $error("parity error ignored");
   property p_esc; rx_esc_err && rx_enable |-> ##[1:3] !rx_enable; endproperty
   a_esc: assert property (p_esc) else $error("escape error ignored");
   property p_hold; tx_char_req && !tx_enable |=> tx_char_type == `SPL_CH_NULL; endproperty
   a_hold: assert property (p_hold) else $error("character chosen while link idle");
   property p_chg; !$stable(tx_char_type) |-> $past(tx_char_req); endproperty
   a_chg: assert property (p_chg) else $error("character changed without request");
   property p_tcack; tc_ack |-> tx_char_type == `SPL_CH_TIME && $past(tx_char_req); endproperty
   a_tcack: assert property (p_tcack) else $error("time-code ack without time-code");
   property p_tcreq; tc_ack |-> $past(tc_req); endproperty
   a_tcreq: assert property (p_tcreq) else $error("time-code sent unrequested");
endmodule // spl_link_if_sva
bind spl_link_if spl_link_if_sva u_sva (
   .pclk(pclk),
   .presetn(presetn),
   .rx_par_err(rx_par_err),
   .rx_esc_err(rx_esc_err),
   .rx_enable(rx_enable),
   .tx_enable(tx_enable),
   .tx_char_req(tx_char_req),
   .tx_char_type(tx_char_type),
   .tc_req(tc_req),
   .tc_ack(tc_ack)
);

// *** testbench/spl_remote_node.sv ***
`timescale 1ns/1ps
`include "spl_defines.vh"
module spl_remote_node (
   input wire pclk,
   input wire presetn,
   input wire [3:0] req_gap,
   input wire send_stb,
   input wire [2:0] send_type,
   input wire [7:0] send_data,
   output reg tx_char_req,
   input wire [2:0] tx_char_type,
   input wire [7:0] tx_char_data,
   output reg rx_char_valid,
   output reg [2:0] rx_char_type,
   output reg [7:0] rx_char_data,
   output reg [7:0] n_fct,
   output reg [7:0] n_nchar,
   output reg [7:0] n_time,
   output reg [7:0] last_data
);
   reg [3:0] gap_ff;
   reg taken_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff <= 4'h0; taken_ff <= 1'b0; tx_char_req <= 1'b0;
         rx_char_valid <= 1'b0; rx_char_type <= 3'h0; rx_char_data <= 8'h00;
         n_fct <= 8'h00; n_nchar <= 8'h00; n_time <= 8'h00; last_data <= 8'h00;
      end else begin
         // request pacing set by req_gap: 0 is every cycle, larger is a slow line
         tx_char_req <= (gap_ff == req_gap);
         gap_ff <= (gap_ff == req_gap) ? 4'h0 : gap_ff + 4'h1;
         taken_ff <= tx_char_req;
         if (taken_ff) begin
            case (tx_char_type)
               `SPL_CH_FCT: n_fct <= n_fct + 8'h01;
               `SPL_CH_NCHAR: begin n_nchar <= n_nchar + 8'h01; last_data <= tx_char_data; end
               `SPL_CH_TIME: begin n_time <= n_time + 8'h01; last_data <= tx_char_data; end
               default: ;
            endcase
         end
         rx_char_valid <= send_stb;
         // lines between characters never hold the last value
         rx_char_type <= send_stb ? send_type : ~rx_char_type;
         rx_char_data <= send_stb ? send_data : ~rx_char_data;
      end
   end
endmodule // spl_remote_node

// *** testbench/test_spacewire_port_link_interface.sv ***
`timescale 1ns/1ps
`include "spl_defines.vh"
module test_spacewire_port_link_interface;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg txf_wvalid = 1'b0;
   reg [8:0] txf_wdata = 9'h000;
   reg rxf_rready = 1'b0;
   reg tc_req = 1'b0;
   reg [7:0] tc_data = 8'h00;
   reg rx_par_err = 1'b0;
   reg rx_esc_err = 1'b0;
   reg [3:0] gap = 4'h3;
   reg s_stb = 1'b0;
   reg [2:0] s_type = 3'h0;
   reg [7:0] s_data = 8'h00;
   wire [31:0] prdata;
   wire pready, pslverr, txf_wready, rxf_rvalid, tc_ack, rx_char_valid, rx_enable;
   wire tx_char_req, tx_enable, tx_bit_en;
   wire tc_rx_valid;
   wire [7:0] tc_rx_data;
   wire [8:0] rxf_rdata;
   wire [2:0] rx_char_type, tx_char_type;
   wire [7:0] rx_char_data, tx_char_data, n_fct, n_nchar, n_time, last_data;
   reg [31:0] rd_q;
   reg err_q;
   integer miscompares = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer tc_seen = 0;
   integer i, k;
   always #10 pclk = ~pclk;

   spl_link_if DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_req(1'b0), .txf_wvalid(txf_wvalid), .txf_wready(txf_wready),
      .txf_wdata(txf_wdata), .rxf_rvalid(rxf_rvalid), .rxf_rready(rxf_rready),
      .rxf_rdata(rxf_rdata), .tc_req(tc_req), .tc_data(tc_data), .tc_ack(tc_ack),
      .tc_rx_valid(tc_rx_valid), .tc_rx_data(tc_rx_data), .rx_char_valid(rx_char_valid),
      .rx_char_type(rx_char_type), .rx_char_data(rx_char_data), .rx_par_err(rx_par_err),
      .rx_esc_err(rx_esc_err), .rx_disconnect(1'b0), .rx_enable(rx_enable),
      .tx_char_req(tx_char_req), .tx_char_type(tx_char_type), .tx_char_data(tx_char_data),
      .tx_enable(tx_enable), .tx_bit_en(tx_bit_en));

   spl_remote_node u_node (.pclk(pclk), .presetn(presetn), .req_gap(gap), .send_stb(s_stb),
      .send_type(s_type), .send_data(s_data), .tx_char_req(tx_char_req),
      .tx_char_type(tx_char_type), .tx_char_data(tx_char_data),
      .rx_char_valid(rx_char_valid), .rx_char_type(rx_char_type),
      .rx_char_data(rx_char_data), .n_fct(n_fct), .n_nchar(n_nchar), .n_time(n_time),
      .last_data(last_data));

   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd_q = prdata;
         err_q = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // polls the state field; gives up after a bounded number of reads
   task wait_state(input logic [2:0] s);
      integer n;
      begin
         n = 0;
         apb(1'b0, `SPL_OFF_STATUS, 32'h0);
         while (rd_q[2:0] !== s && n < 600) begin
            apb(1'b0, `SPL_OFF_STATUS, 32'h0);
            n = n + 1;
         end
         chk("link state", {29'h0, s}, {29'h0, rd_q[2:0]});
      end
   endtask

   task send(input logic [2:0] t, input logic [7:0] d);
      begin
         @(posedge pclk);
         s_stb <= 1'b1; s_type <= t; s_data <= d;
         @(posedge pclk);
         s_stb <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (tc_rx_valid === 1'b1) tc_seen <= tc_seen + 1;
      if (cyc == 30000) begin
         miscompares = miscompares + 1;
         $display("wrong value run length expected below 30000 seen %0d", cyc);
         close_out;
      end
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SPL_OFF_PORT_CTRL, 32'h0); chk("port_control_reg", 32'h0, rd_q);
      apb(1'b0, `SPL_OFF_INIT_DIV, 32'h0); chk("init_divisor", 32'h4, rd_q);
      apb(1'b0, `SPL_OFF_CREDIT, 32'h0); chk("credit readback", 32'h0, rd_q);
      apb(1'b0, 8'h10, 32'h0); chk("unmapped data", 32'h0, rd_q);
      chk("unmapped error", 32'h1, {31'h0, err_q});
      // 50 MHz line clock: 50 / 10 - 1 gives the 10 Mbit/s start-up rate
      apb(1'b1, `SPL_OFF_INIT_DIV, 32'h4);
      wait_state(3'h2);
      for (k = 1; k < 3; k = k + 1) begin
         @(posedge pclk);
         {rx_esc_err, rx_par_err} <= k[1:0];
         @(posedge pclk);
         {rx_esc_err, rx_par_err} <= 2'b00;
         wait_state(3'h0);
         wait_state(3'h2);
      end
      apb(1'b1, `SPL_OFF_PORT_CTRL, 32'h3);
      repeat (60) @(posedge pclk);
      apb(1'b0, `SPL_OFF_STATUS, 32'h0); chk("disabled state", 32'h2, {29'h0, rd_q[2:0]});
      apb(1'b1, `SPL_OFF_PORT_CTRL, 32'h2);
      wait_state(3'h3);
      send(`SPL_CH_NULL, 8'h00);
      wait_state(3'h4);
      send(`SPL_CH_FCT, 8'h00);
      wait_state(3'h5);
      repeat (60) @(posedge pclk);
      apb(1'b0, `SPL_OFF_CREDIT, 32'h0); chk("credit readback", 32'h3808, rd_q);
      chk("fct count", 32'h7, {24'h0, n_fct});
      apb(1'b1, `SPL_OFF_PORT_CTRL, 32'h0302);
      repeat (8) @(posedge pclk);
      i = 0;
      repeat (40) begin
         @(posedge pclk);
         if (tx_bit_en === 1'b1) i = i + 1;
      end
      chk("bit enables", 32'h0000000A, i);
      gap <= 4'h0;
      for (k = 0; k < 3; k = k + 1) begin
         @(posedge pclk);
         txf_wvalid <= 1'b1;
         txf_wdata <= 9'h010 + k[8:0];
         @(posedge pclk);
         while (txf_wready !== 1'b1) @(posedge pclk);
         txf_wvalid <= 1'b0;
      end
      repeat (60) @(posedge pclk);
      chk("data sent", 32'h3, {24'h0, n_nchar});
      chk("last data", 32'h12, {24'h0, last_data});
      apb(1'b0, `SPL_OFF_CREDIT, 32'h0); chk("tx credit", 32'h5, {26'h0, rd_q[5:0]});
      send(`SPL_CH_NCHAR, 8'hA5);
      chk("rx valid", 32'h1, {31'h0, rxf_rvalid});
      chk("rx data", 32'h0A5, {23'h0, rxf_rdata});
      @(posedge pclk);
      rxf_rready <= 1'b1;
      @(posedge pclk);
      rxf_rready <= 1'b0;
      send(`SPL_CH_FCT, 8'h00);
      apb(1'b0, `SPL_OFF_STATUS, 32'h0); chk("rx count", 32'h0, {24'h0, rd_q[23:16]});
      @(posedge pclk);
      tc_req <= 1'b1;
      tc_data <= 8'h2A;
      i = 0;
      @(posedge pclk);
      while (tc_ack !== 1'b1 && i < 50) begin
         @(posedge pclk);
         i = i + 1;
      end
      tc_req <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("time-codes sent", 32'h1, {24'h0, n_time});
      chk("time-code value", 32'h2A, {24'h0, last_data});
      send(`SPL_CH_TIME, 8'h15);
      repeat (2) @(posedge pclk);
      chk("time-code pulses", 32'h1, tc_seen);
      chk("time-code rx", 32'h15, {24'h0, tc_rx_data});
      // credit climbs 13 to 53 without fault; the next token overflows it
      repeat (5) send(`SPL_CH_FCT, 8'h00);
      apb(1'b0, `SPL_OFF_STATUS, 32'h0); chk("state at 53", 32'h5, {29'h0, rd_q[2:0]});
      send(`SPL_CH_FCT, 8'h00);
      wait_state(3'h0);
      close_out;
   end
endmodule // test_spacewire_port_link_interface
